// ### src/pci_window_pkg.sv
// Constants and carrier types for the PCI window and translation logic
package pci_window_pkg;

  // Configuration offsets (byte offsets in each side's config space)
  localparam logic [7:0]  CFG_BAR2_OFF      = 8'h18;
  localparam logic [7:0]  CFG_IN_XLATE_OFF  = 8'h40;
  localparam logic [7:0]  CFG_IN_SIZE_OFF   = 8'h44;
  localparam logic [7:0]  CFG_OUT_REMAP_OFF = 8'h48;
  localparam logic [7:0]  CFG_OUT_SIZE_OFF  = 8'h4C;
  localparam logic [7:0]  CFG_PRECFG_OFF    = 8'h50;
  localparam logic [7:0]  CFG_BR_BAR0_OFF   = 8'h60;
  localparam logic [7:0]  CFG_STRIDE        = 8'h04;
  localparam logic [7:0]  CFG_UTIL_BASE_OFF = 8'h78;

  // Field positions
  localparam int          PRECFG_DONE_BIT   = 0;
  localparam int          IO_SPACE_BIT      = 0;

  // Window sizes as address masks
  localparam logic [31:0] WIN_64M_MASK      = 32'hFC00_0000;
  localparam logic [31:0] REGION_1M_MASK    = 32'hFFF0_0000;

  // Reset values
  localparam logic [31:0] IN_XLATE_RST      = 32'h0000_0000;
  localparam logic [31:0] OUT_REMAP_RST     = 32'h0000_0000;
  localparam logic [31:0] UTIL_BASE_RST     = 32'h0000_0000;
  localparam logic [31:0] BAR_RST           = 32'h0000_0000;

  // Local bus targets of the segmentation units
  localparam logic [31:0] SEG0_LOCAL_BASE   = 32'hC000_0000;
  localparam logic [31:0] SEG1_LOCAL_BASE   = 32'hC800_0000;

  // Window indices
  localparam int          NWIN     = 7;
  localparam int          NBR      = 4;
  localparam int          W_IN     = 0;
  localparam int          W_OUT    = 1;
  localparam int          W_BR0    = 2;
  localparam int          W_UTIL   = 6;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [7:0]  off;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [31:0] addr;
  } mem_req_s;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_CFG_MEM,
    TGT_CFG_IO,
    TGT_SEG0,
    TGT_SEG1
  } target_e;

endpackage : pci_window_pkg

// ### src/window_decode.sv
// Base/mask window hit detector with offset extraction
`timescale 1ns/100ps
`default_nettype none
module window_decode (
  input  wire logic [31:0] base,
  input  wire logic [31:0] mask,
  input  wire logic [31:0] addr,
  input  wire logic        en,
  output logic             hit,
  output logic [31:0]      offset
);
  assign hit    = en && ((addr & mask) == (base & mask));
  assign offset = addr & ~mask;
endmodule : window_decode
`default_nettype wire

// ### src/pci_window_translation.sv
// Inbound/outbound windows, bridge regions and config spaces of the board
// Function
// - Host and local config spaces are separate; neither reaches the other.
// - Host config cycles are retried until local preconfiguration is marked done.
// - Inbound window 0 requests 64 MB and its translation resets to zero.
// - Inbound hits map window base to DRAM at the translation value (zero after reset), keeping the offset.
// - Every claimed inbound transaction is forwarded onto the local segment.
// - Outbound window 0 is 64 MB with remap zero by default.
// - A new outbound remap value moves the window on the backplane.
// - The local-bus bridge requests four 1 MB regions.
// - Third bridge region goes to segmentation unit 0 at 0xC00xxxxx.
// - Fourth bridge region goes to segmentation unit 1 at 0xC80xxxxx.
// - Bridge is big-endian; unit registers and own registers both pass unswapped, swapping is the requester's.
// - Utilities block base sits at config offset 0x78, read back locally.
`timescale 1ns/100ps
`default_nettype none
module pci_window_translation (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire pci_window_pkg::cfg_req_s    host_cfg,
  output var  logic                        host_cfg_ack,
  output var  logic                        host_cfg_retry,
  output var  logic [31:0]                 host_cfg_rdata,
  input  wire pci_window_pkg::cfg_req_s    loc_cfg,
  output var  logic                        loc_cfg_ack,
  output var  logic [31:0]                 loc_cfg_rdata,
  input  wire pci_window_pkg::mem_req_s    host_mem,
  output var  logic                        inbound_claim,
  output var  pci_window_pkg::mem_req_s    inbound_fwd,
  input  wire pci_window_pkg::mem_req_s    local_mem,
  output var  logic                        outbound_claim,
  output var  pci_window_pkg::mem_req_s    outbound_fwd,
  output var  pci_window_pkg::mem_req_s    lbus_fwd,
  output var  pci_window_pkg::target_e     lbus_target,
  output var  logic                        util_hit
);

  // Configuration state
  logic [31:0] host_bar2_q, host_bar2_d;
  logic        host_bar2_set_q, host_bar2_set_d;
  logic [31:0] out_base_q, out_base_d;
  logic        out_base_set_q, out_base_set_d;
  logic [31:0] in_xlate_q, in_xlate_d;
  logic [31:0] out_remap_q, out_remap_d;
  logic        precfg_done_q, precfg_done_d;
  logic [31:0] util_base_q, util_base_d;
  logic [31:0] br_bar_q [pci_window_pkg::NBR];
  logic [31:0] br_bar_d [pci_window_pkg::NBR];
  logic [pci_window_pkg::NBR-1:0] br_set_q, br_set_d;
  logic        host_ack_d, host_retry_d, loc_ack_d;
  logic [31:0] host_rdata_d, loc_rdata_d;
  logic                        in_claim_d, out_claim_d, util_hit_d;
  pci_window_pkg::mem_req_s    in_fwd_d, out_fwd_d, lbus_fwd_d;
  pci_window_pkg::target_e     lbus_tgt_d;
  logic [31:0]                 win_base [pci_window_pkg::NWIN];
  logic [31:0]                 win_mask [pci_window_pkg::NWIN];
  logic [31:0]                 win_addr [pci_window_pkg::NWIN];
  logic [31:0]                 win_off  [pci_window_pkg::NWIN];
  logic [pci_window_pkg::NWIN-1:0] win_en, win_hit;
  always_comb begin
    win_base[pci_window_pkg::W_IN]   = host_bar2_q;
    win_mask[pci_window_pkg::W_IN]   = pci_window_pkg::WIN_64M_MASK;
    win_addr[pci_window_pkg::W_IN]   = host_mem.addr;
    // Inbound window only live once the host could assign it
    win_en[pci_window_pkg::W_IN]     = precfg_done_q && host_bar2_set_q;
    win_base[pci_window_pkg::W_OUT]  = out_base_q;
    win_mask[pci_window_pkg::W_OUT]  = pci_window_pkg::WIN_64M_MASK;
    win_addr[pci_window_pkg::W_OUT]  = local_mem.addr;
    win_en[pci_window_pkg::W_OUT]    = out_base_set_q;
    win_base[pci_window_pkg::W_UTIL] = util_base_q;
    win_mask[pci_window_pkg::W_UTIL] = pci_window_pkg::REGION_1M_MASK;
    win_addr[pci_window_pkg::W_UTIL] = local_mem.addr;
    win_en[pci_window_pkg::W_UTIL]   = 1'b1;
    for (int i = 0; i < pci_window_pkg::NBR; i++) begin
      win_base[pci_window_pkg::W_BR0+i] = br_bar_q[i];
      win_mask[pci_window_pkg::W_BR0+i] = pci_window_pkg::REGION_1M_MASK;
      win_addr[pci_window_pkg::W_BR0+i] = local_mem.addr;
      win_en[pci_window_pkg::W_BR0+i]   = br_set_q[i];
    end
  end
  genvar g;
  generate
    for (g = 0; g < pci_window_pkg::NWIN; g++) begin : g_win
      window_decode u_dec (
        .base   (win_base[g]),
        .mask   (win_mask[g]),
        .addr   (win_addr[g]),
        .en     (win_en[g]),
        .hit    (win_hit[g]),
        .offset (win_off[g])
      );
    end
  endgenerate
  // Config spaces: host side only sees its BAR, local side owns the rest
  always_comb begin
    host_bar2_d     = host_bar2_q;
    host_bar2_set_d = host_bar2_set_q;
    out_base_d      = out_base_q;
    out_base_set_d  = out_base_set_q;
    in_xlate_d      = in_xlate_q;
    out_remap_d     = out_remap_q;
    precfg_done_d   = precfg_done_q;
    util_base_d     = util_base_q;
    br_bar_d        = br_bar_q;
    br_set_d        = br_set_q;
    host_ack_d      = 1'b0;
    host_retry_d    = 1'b0;
    host_rdata_d    = 32'h0000_0000;
    loc_ack_d       = 1'b0;
    loc_rdata_d     = 32'h0000_0000;
    if (host_cfg.valid) begin
      if (!precfg_done_q) begin
        host_retry_d = 1'b1;
      end else begin
        host_ack_d = 1'b1;
        if (host_cfg.off == pci_window_pkg::CFG_BAR2_OFF) begin
          // Mask gives the 64 MB size request on read-back
          host_rdata_d = host_bar2_q & pci_window_pkg::WIN_64M_MASK;
          if (host_cfg.wr) begin
            host_bar2_d     = host_cfg.wdata & pci_window_pkg::WIN_64M_MASK;
            host_bar2_set_d = 1'b1;
          end
        end
      end
    end
    if (loc_cfg.valid) begin
      loc_ack_d = 1'b1;
      case (loc_cfg.off)
        pci_window_pkg::CFG_BAR2_OFF: begin
          loc_rdata_d = out_base_q;
          if (loc_cfg.wr) begin
            out_base_d     = loc_cfg.wdata & pci_window_pkg::WIN_64M_MASK;
            out_base_set_d = 1'b1;
          end
        end
        pci_window_pkg::CFG_IN_XLATE_OFF: begin
          loc_rdata_d = in_xlate_q;
          if (loc_cfg.wr) in_xlate_d = loc_cfg.wdata & pci_window_pkg::WIN_64M_MASK;
        end
        pci_window_pkg::CFG_IN_SIZE_OFF,
        pci_window_pkg::CFG_OUT_SIZE_OFF: begin
          loc_rdata_d = pci_window_pkg::WIN_64M_MASK;
        end
        pci_window_pkg::CFG_OUT_REMAP_OFF: begin
          loc_rdata_d = out_remap_q;
          if (loc_cfg.wr) out_remap_d = loc_cfg.wdata & pci_window_pkg::WIN_64M_MASK;
        end
        pci_window_pkg::CFG_PRECFG_OFF: begin
          loc_rdata_d[pci_window_pkg::PRECFG_DONE_BIT] = precfg_done_q;
          if (loc_cfg.wr) begin
            // Local side releases the host retry here
            precfg_done_d = loc_cfg.wdata[pci_window_pkg::PRECFG_DONE_BIT];
          end
        end
        pci_window_pkg::CFG_UTIL_BASE_OFF: begin
          loc_rdata_d = util_base_q;
          if (loc_cfg.wr) util_base_d = loc_cfg.wdata & pci_window_pkg::REGION_1M_MASK;
        end
        default: begin
          for (int i = 0; i < pci_window_pkg::NBR; i++) begin
            if (loc_cfg.off == pci_window_pkg::CFG_BR_BAR0_OFF
                + 8'(i) * pci_window_pkg::CFG_STRIDE) begin
              loc_rdata_d = br_bar_q[i];
              if (i == 1) loc_rdata_d[pci_window_pkg::IO_SPACE_BIT] = 1'b1;
              if (loc_cfg.wr) begin
                br_bar_d[i] = loc_cfg.wdata & pci_window_pkg::REGION_1M_MASK;
                br_set_d[i] = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_bar2_q     <= pci_window_pkg::BAR_RST;
      host_bar2_set_q <= 1'b0;
      out_base_q      <= pci_window_pkg::BAR_RST;
      out_base_set_q  <= 1'b0;
      in_xlate_q      <= pci_window_pkg::IN_XLATE_RST;
      out_remap_q     <= pci_window_pkg::OUT_REMAP_RST;
      precfg_done_q   <= 1'b0;
      util_base_q     <= pci_window_pkg::UTIL_BASE_RST;
      br_bar_q        <= '{default: pci_window_pkg::BAR_RST};
      br_set_q        <= '0;
      host_cfg_ack    <= 1'b0;
      host_cfg_retry  <= 1'b0;
      host_cfg_rdata  <= 32'h0000_0000;
      loc_cfg_ack     <= 1'b0;
      loc_cfg_rdata   <= 32'h0000_0000;
    end else begin
      host_bar2_q     <= host_bar2_d;
      host_bar2_set_q <= host_bar2_set_d;
      out_base_q      <= out_base_d;
      out_base_set_q  <= out_base_set_d;
      in_xlate_q      <= in_xlate_d;
      out_remap_q     <= out_remap_d;
      precfg_done_q   <= precfg_done_d;
      util_base_q     <= util_base_d;
      br_bar_q        <= br_bar_d;
      br_set_q        <= br_set_d;
      host_cfg_ack    <= host_ack_d;
      host_cfg_retry  <= host_retry_d;
      host_cfg_rdata  <= host_rdata_d;
      loc_cfg_ack     <= loc_ack_d;
      loc_cfg_rdata   <= loc_rdata_d;
    end
  end
  // Address decode and translation
  always_comb begin
    in_claim_d  = 1'b0;
    out_claim_d = 1'b0;
    util_hit_d  = 1'b0;
    in_fwd_d    = '0;
    out_fwd_d   = '0;
    lbus_fwd_d  = '0;
    lbus_tgt_d  = pci_window_pkg::TGT_NONE;
    if (host_mem.valid && win_hit[pci_window_pkg::W_IN]) begin
      in_claim_d     = 1'b1;
      in_fwd_d.valid = 1'b1;
      in_fwd_d.wr    = host_mem.wr;
      // Translation is 64 MB aligned, so OR equals add
      in_fwd_d.addr  = win_off[pci_window_pkg::W_IN] | in_xlate_q;
    end
    if (local_mem.valid) begin
      lbus_fwd_d.wr = local_mem.wr;
      if (win_hit[pci_window_pkg::W_OUT]) begin
        out_claim_d     = 1'b1;
        out_fwd_d.valid = 1'b1;
        out_fwd_d.wr    = local_mem.wr;
        out_fwd_d.addr  = win_off[pci_window_pkg::W_OUT] | out_remap_q;
      end else if (win_hit[pci_window_pkg::W_BR0+2]) begin
        // Unit registers pass unswapped: bridge runs big-endian
        lbus_fwd_d.valid = 1'b1;
        lbus_tgt_d       = pci_window_pkg::TGT_SEG0;
        lbus_fwd_d.addr  = pci_window_pkg::SEG0_LOCAL_BASE
                         | win_off[pci_window_pkg::W_BR0+2];
      end else if (win_hit[pci_window_pkg::W_BR0+3]) begin
        lbus_fwd_d.valid = 1'b1;
        lbus_tgt_d       = pci_window_pkg::TGT_SEG1;
        lbus_fwd_d.addr  = pci_window_pkg::SEG1_LOCAL_BASE
                         | win_off[pci_window_pkg::W_BR0+3];
      end else if (win_hit[pci_window_pkg::W_BR0]) begin
        lbus_fwd_d.valid = 1'b1;
        lbus_tgt_d       = pci_window_pkg::TGT_CFG_MEM;
        lbus_fwd_d.addr  = win_off[pci_window_pkg::W_BR0];
      end else if (win_hit[pci_window_pkg::W_BR0+1]) begin
        lbus_fwd_d.valid = 1'b1;
        lbus_tgt_d       = pci_window_pkg::TGT_CFG_IO;
        lbus_fwd_d.addr  = win_off[pci_window_pkg::W_BR0+1];
      end else if (win_hit[pci_window_pkg::W_UTIL]) begin
        util_hit_d = 1'b1;
      end
      // Any other address is left unclaimed
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inbound_claim  <= 1'b0;
      inbound_fwd    <= '0;
      outbound_claim <= 1'b0;
      outbound_fwd   <= '0;
      lbus_fwd       <= '0;
      lbus_target    <= pci_window_pkg::TGT_NONE;
      util_hit       <= 1'b0;
    end else begin
      inbound_claim  <= in_claim_d;
      inbound_fwd    <= in_fwd_d;
      outbound_claim <= out_claim_d;
      outbound_fwd   <= out_fwd_d;
      lbus_fwd       <= lbus_fwd_d;
      lbus_target    <= lbus_tgt_d;
      util_hit       <= util_hit_d;
    end
  end

  property p_host_retry;
    @(posedge clk) disable iff (rst)
    host_cfg.valid && !precfg_done_q |=> host_cfg_retry && !host_cfg_ack;
  endproperty
  a_host_retry: assert property (p_host_retry) else $error("host cfg not retried");
  property p_cfg_isolated;
    @(posedge clk) disable iff (rst)
    loc_cfg.valid && loc_cfg.wr && !host_cfg.valid |=> $stable(host_bar2_q);
  endproperty
  a_cfg_isolated: assert property (p_cfg_isolated) else $error("host space changed");
  property p_in_xlate;
    @(posedge clk) disable iff (rst)
    host_mem.valid && win_hit[pci_window_pkg::W_IN] |=> inbound_claim && inbound_fwd.valid
      && inbound_fwd.addr == (($past(host_mem.addr) & ~pci_window_pkg::WIN_64M_MASK)
      | $past(in_xlate_q));
  endproperty
  a_in_xlate: assert property (p_in_xlate) else $error("inbound translation wrong");
  property p_out_remap;
    @(posedge clk) disable iff (rst)
    local_mem.valid && win_hit[pci_window_pkg::W_OUT] |=> outbound_claim
      && outbound_fwd.addr == (($past(local_mem.addr) & ~pci_window_pkg::WIN_64M_MASK)
      | $past(out_remap_q));
  endproperty
  a_out_remap: assert property (p_out_remap) else $error("outbound remap wrong");
  property p_seg0;
    @(posedge clk) disable iff (rst)
    lbus_target == pci_window_pkg::TGT_SEG0 |-> lbus_fwd.valid
      && (lbus_fwd.addr & pci_window_pkg::REGION_1M_MASK) == pci_window_pkg::SEG0_LOCAL_BASE;
  endproperty
  a_seg0: assert property (p_seg0) else $error("unit 0 address wrong");
  property p_seg1;
    @(posedge clk) disable iff (rst)
    lbus_target == pci_window_pkg::TGT_SEG1 |-> lbus_fwd.valid
      && (lbus_fwd.addr & pci_window_pkg::REGION_1M_MASK) == pci_window_pkg::SEG1_LOCAL_BASE;
  endproperty
  a_seg1: assert property (p_seg1) else $error("unit 1 address wrong");
  property p_miss;
    @(posedge clk) disable iff (rst)
    local_mem.valid && win_hit[pci_window_pkg::W_UTIL:pci_window_pkg::W_OUT] == '0
      |=> !outbound_claim && !lbus_fwd.valid && !util_hit;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped address claimed");
  property p_region_size;
    @(posedge clk) disable iff (rst)
    loc_cfg.valid && loc_cfg.wr && loc_cfg.off == pci_window_pkg::CFG_BR_BAR0_OFF
      |=> (br_bar_q[0] & ~pci_window_pkg::REGION_1M_MASK) == 32'h0000_0000 && br_set_q[0];
  endproperty
  a_region_size: assert property (p_region_size) else $error("region not 1 MB");
  property p_util_read;
    @(posedge clk) disable iff (rst)
    loc_cfg.valid && !loc_cfg.wr && loc_cfg.off == pci_window_pkg::CFG_UTIL_BASE_OFF
      |=> loc_cfg_ack && loc_cfg_rdata == $past(util_base_q);
  endproperty
  a_util_read: assert property (p_util_read) else $error("utilities base wrong");

endmodule : pci_window_translation
`default_nettype wire

// ### sim/host_agent.sv
// Backplane requester model: host configuration and memory cycles
`timescale 1ns/100ps
`default_nettype none
module host_agent (
  input  wire logic                     clk,
  input  wire logic                     ack,
  input  wire logic                     retry,
  input  wire logic [31:0]              rdata,
  input  wire logic                     claim,
  input  wire pci_window_pkg::mem_req_s fwd,
  output var  pci_window_pkg::cfg_req_s cfg,
  output var  pci_window_pkg::mem_req_s mem
);
  initial begin
    cfg = '0;
    mem = '0;
  end

  // One attempt only; the caller decides whether to try again after a retry
  task automatic cfg_cycle(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                           output logic [31:0] rd, output logic got_ack,
                           output logic got_retry);
    rd        = '0;
    got_ack   = 1'b0;
    got_retry = 1'b0;
    @(negedge clk);
    cfg <= '{valid: 1'b1, wr: wr, off: off, wdata: wd};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      // Released lines show inverted data so stale values never look valid
      if (i == 0) cfg <= '{valid: 1'b0, wr: ~wr, off: ~off, wdata: ~wd};
      if (ack === 1'b1) begin
        got_ack = 1'b1;
        rd      = rdata;
      end
      if (retry === 1'b1) got_retry = 1'b1;
    end
  endtask : cfg_cycle

  task automatic mem_cycle(input logic wr, input logic [31:0] a, output logic got_claim,
                           output logic [31:0] fa, output logic fw);
    got_claim = 1'b0;
    fa        = '0;
    fw        = 1'b0;
    @(negedge clk);
    mem <= '{valid: 1'b1, wr: wr, addr: a};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      if (i == 0) mem <= '{valid: 1'b0, wr: ~wr, addr: ~a};
      if (claim === 1'b1 && fwd.valid === 1'b1) begin
        got_claim = 1'b1;
        fa        = fwd.addr;
        fw        = fwd.wr;
      end
    end
  endtask : mem_cycle
endmodule : host_agent
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the window and translation logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module testbench;
  logic                     clk;
  logic                     rst;
  pci_window_pkg::cfg_req_s host_cfg;
  pci_window_pkg::cfg_req_s loc_cfg;
  pci_window_pkg::mem_req_s host_mem;
  pci_window_pkg::mem_req_s local_mem;
  pci_window_pkg::mem_req_s inbound_fwd;
  pci_window_pkg::mem_req_s outbound_fwd;
  pci_window_pkg::mem_req_s lbus_fwd;
  pci_window_pkg::target_e  lbus_target;
  logic                     host_cfg_ack;
  logic                     host_cfg_retry;
  logic                     loc_cfg_ack;
  logic                     inbound_claim;
  logic                     outbound_claim;
  logic                     util_hit;
  logic [31:0]              host_cfg_rdata;
  logic [31:0]              loc_cfg_rdata;
  int                       mismatches;
  int                       checks;
  logic [31:0]              seed;
  logic [31:0]              rd;
  logic [31:0]              hb;
  logic [31:0]              off;
  logic [31:0]              rm;
  logic [31:0]              ub;
  logic [31:0]              oa;
  logic [31:0]              la;
  logic [31:0]              rbase [4];
  logic [2:0]               tg;
  logic                     ok;
  logic                     rt;
  logic                     oc;
  logic                     lv;
  logic                     uh;
  logic                     w;

  pci_window_translation u_dut (
    .clk(clk), .rst(rst), .host_cfg(host_cfg), .host_cfg_ack(host_cfg_ack),
    .host_cfg_retry(host_cfg_retry), .host_cfg_rdata(host_cfg_rdata), .loc_cfg(loc_cfg),
    .loc_cfg_ack(loc_cfg_ack), .loc_cfg_rdata(loc_cfg_rdata), .host_mem(host_mem),
    .inbound_claim(inbound_claim), .inbound_fwd(inbound_fwd), .local_mem(local_mem),
    .outbound_claim(outbound_claim), .outbound_fwd(outbound_fwd), .lbus_fwd(lbus_fwd),
    .lbus_target(lbus_target), .util_hit(util_hit)
  );

  host_agent u_host (
    .clk(clk), .ack(host_cfg_ack), .retry(host_cfg_retry), .rdata(host_cfg_rdata),
    .claim(inbound_claim), .fwd(inbound_fwd), .cfg(host_cfg), .mem(host_mem)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : nxt

  function automatic logic [2:0] exp_tgt(input int i);
    case (i)
      0:       return pci_window_pkg::TGT_CFG_MEM;
      1:       return pci_window_pkg::TGT_CFG_IO;
      2:       return pci_window_pkg::TGT_SEG0;
      default: return pci_window_pkg::TGT_SEG1;
    endcase
  endfunction : exp_tgt

  function automatic logic [31:0] exp_lbus(input int i, input logic [31:0] o);
    return ((i == 2) ? 32'hC000_0000 : 32'hC800_0000) | o;
  endfunction : exp_lbus

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic lcfg(input logic wr, input logic [7:0] o, input logic [31:0] wd,
                      output logic [31:0] r, output logic a);
    r = '0;
    a = 1'b0;
    @(negedge clk);
    // Words already in bus byte order; swapping is the requester's
    loc_cfg <= '{valid: 1'b1, wr: wr, off: o, wdata: wd};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      if (i == 0) loc_cfg <= '{valid: 1'b0, wr: ~wr, off: ~o, wdata: ~wd};
      if (loc_cfg_ack === 1'b1) begin
        a = 1'b1;
        r = loc_cfg_rdata;
      end
    end
  endtask : lcfg

  // Captures every local-side answer so a wrong route shows as an extra hit
  task automatic lmem(input logic [31:0] a);
    oc = 1'b0;
    oa = '0;
    lv = 1'b0;
    la = '0;
    tg = '0;
    uh = 1'b0;
    @(negedge clk);
    local_mem <= '{valid: 1'b1, wr: 1'b0, addr: a};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      if (i == 0) local_mem <= '{valid: 1'b0, wr: 1'b1, addr: ~a};
      if (outbound_claim === 1'b1 && outbound_fwd.valid === 1'b1) begin
        oc = 1'b1;
        oa = outbound_fwd.addr;
      end
      if (lbus_fwd.valid === 1'b1) begin
        lv = 1'b1;
        la = lbus_fwd.addr;
        tg = lbus_target;
      end
      if (util_hit === 1'b1) uh = 1'b1;
    end
  endtask : lmem

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(8 * 5000);
    mismatches++;
    complete_run();
  end

  initial begin
    rst       = 1'b1;
    loc_cfg   = '0;
    local_mem = '0;
    seed      = 32'hE5ED_BCA6;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    lcfg(1'b0, 8'h44, '0, rd, ok);
    `CHK("in_size", 32'hFC00_0000, rd);
    lcfg(1'b0, 8'h40, '0, rd, ok);
    `CHK("in_xlate", 32'h0, rd);
    lcfg(1'b0, 8'h4C, '0, rd, ok);
    `CHK("out_size", 32'hFC00_0000, rd);
    lcfg(1'b0, 8'h48, '0, rd, ok);
    `CHK("out_remap", 32'h0, rd);
    lcfg(1'b0, 8'h78, '0, rd, ok);
    `CHK("util_base_rst", 32'h0, rd);
    $display("test reset_values done");
    u_host.cfg_cycle(1'b1, 8'h18, 32'hFFFF_FFFF, rd, ok, rt);
    `CHK("early_retry", 1'b1, rt);
    `CHK("early_ack", 1'b0, ok);
    lcfg(1'b1, 8'h50, 32'h0000_0001, rd, ok);
    `CHK("precfg_ack", 1'b1, ok);
    u_host.cfg_cycle(1'b0, 8'h18, '0, rd, ok, rt);
    `CHK("bar_untouched", 32'h0, rd);
    `CHK("late_retry", 1'b0, rt);
    `CHK("late_ack", 1'b1, ok);
    hb = nxt();
    u_host.cfg_cycle(1'b1, 8'h18, hb, rd, ok, rt);
    hb = hb & 32'hFC00_0000;
    u_host.cfg_cycle(1'b0, 8'h18, '0, rd, ok, rt);
    `CHK("host_bar", hb, rd);
    lcfg(1'b0, 8'h18, '0, rd, ok);
    `CHK("local_bar_separate", 32'h0, rd);
    $display("test preconfig done");
    for (int i = 0; i < 8; i++) begin
      off = (i == 0) ? 32'h0 : ((i == 1) ? 32'h03FF_FFFC : (nxt() & 32'h03FF_FFFF));
      w   = 1'(nxt() & 32'h1);
      u_host.mem_cycle(w, hb | off, oc, oa, ok);
      `CHK("in_claim", 1'b1, oc);
      `CHK("in_addr", off, oa);
      `CHK("in_wr", w, ok);
    end
    u_host.mem_cycle(1'b0, hb + 32'h0400_0000, oc, oa, ok);
    `CHK("in_miss", 1'b0, oc);
    $display("test inbound done");
    lcfg(1'b1, 8'h18, 32'h4000_0000, rd, ok);
    for (int i = 0; i < 4; i++) begin
      rm  = (i == 0) ? 32'h0 : (nxt() & 32'hFC00_0000);
      off = nxt() & 32'h03FF_FFFF;
      lcfg(1'b1, 8'h48, rm, rd, ok);
      lmem(32'h4000_0000 | off);
      `CHK("out_claim", 1'b1, oc);
      `CHK("out_addr", rm | off, oa);
    end
    lmem(32'h3FFF_FFFC);
    `CHK("out_miss", 1'b0, oc | lv | uh);
    $display("test outbound done");
    for (int i = 0; i < 4; i++) begin
      rbase[i] = (32'h8000_0000 + (32'(i) << 24)) | (nxt() & 32'h00F0_0000);
      lcfg(1'b1, 8'h60 + 8'(4 * i), 32'hFFFF_FFFF, rd, ok);
      lcfg(1'b0, 8'h60 + 8'(4 * i), '0, rd, ok);
      `CHK("region_size", 32'hFFF0_0000 | 32'(i == 1), rd);
      lcfg(1'b1, 8'h60 + 8'(4 * i), rbase[i], rd, ok);
      off = (i == 3) ? 32'h4 : (nxt() & 32'h000F_FFFC);
      lmem(rbase[i] | off);
      `CHK("region_hit", 1'b1, lv);
      `CHK("region_target", exp_tgt(i), tg);
      if (i >= 2) `CHK("seg_addr", exp_lbus(i, off), la);
    end
    $display("test bridge_regions done");
    ub = 32'hB000_0000 | (nxt() & 32'h0FF0_0000);
    lcfg(1'b1, 8'h78, ub | 32'h0000_0ABC, rd, ok);
    lcfg(1'b0, 8'h78, '0, rd, ok);
    `CHK("util_base", ub, rd);
    lmem(ub | 32'h0001_2340);
    `CHK("util_hit", 1'b1, uh);
    lmem(ub + 32'h0010_0000);
    `CHK("util_miss", 1'b0, uh | lv | oc);
    $display("test utilities done");
    lcfg(1'b1, 8'h50, 32'h0000_0000, rd, ok);
    u_host.cfg_cycle(1'b0, 8'h18, '0, rd, ok, rt);
    `CHK("retry_again", 1'b1, rt);
    `CHK("retry_no_ack", 1'b0, ok);
    $display("test retry_again done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
